// ===== tb/afp_ctrl_sva.sv
// port assertions of the fault protection controller
`timescale 1ns/1ps
module afp_ctrl_sva (
  input logic ref_clk,
  input logic nrst,
  input logic uv_gate_drive_supply,
  input logic uv_logic_supply,
  input logic overtemp_warn_flag,
  input logic overtemp_error,
  input logic overcurrent,
  input logic reset_pin_n,
  input logic stage_enable,
  input logic current_limit,
  input logic shutdown_fault_n_out,
  input logic shutdown_fault_n_oe,
  input logic overtemp_warn_n_out,
  input logic overtemp_warn_n_oe,
  input logic overload_protection
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire f = uv_gate_drive_supply | uv_logic_supply | overtemp_error;
  wire rp = reset_pin_n;
  wire ol = overload_protection;
  wire shdn = shutdown_fault_n_oe;
  wire ow = overtemp_warn_n_oe;
  a_od_low: assert property (
    !shutdown_fault_n_out && !overtemp_warn_n_out) else $error("od data");
  a_rst_pins: assert property (!rp [*8] |-> !shdn && !ow) else $error("rst");
  a_rst_off: assert property (!rp [*8] |-> !stage_enable) else $error("on");
  a_flt_off: assert property (f [*8] |-> !stage_enable) else $error("on");
  a_flt_sd: assert property ((f && rp) [*8] |-> shdn) else $error("shdn");
  a_warn_low: assert property ((overtemp_warn_flag && rp) [*8] |-> ow)
    else $error("warn high");
  a_quiet_pins: assert property ((!f && !overtemp_warn_flag && !ol) [*8]
    |-> !shdn && !ow) else $error("pins low");
  a_run_clear: assert property ((!f && rp && !ol) [*8] |-> stage_enable)
    else $error("not run");
  a_latch_off: assert property (ol |-> !stage_enable) else $error("latch");
  c_run: cover property ($rose(stage_enable));
  c_warn: cover property ($rose(ow));
  c_limit: cover property ($rose(current_limit));
endmodule : afp_ctrl_sva
bind afp_ctrl afp_ctrl_sva afp_ctrl_sva_i (.*);

// ===== tb/afp_host_model.sv
// status pins as seen by the host, with pull-ups
`timescale 1ns/1ps
module afp_host_model (
  input  logic shdn_oe,
  input  logic warn_oe,
  output logic shdn_pin,
  output logic warn_pin
);
  assign shdn_pin = !shdn_oe;
  assign warn_pin = !warn_oe;
endmodule : afp_host_model

// ===== tb/test_amp_fault_protection_ctrl.sv
// self-checking bench for the fault protection controller
`timescale 1ns/1ps
module test_amp_fault_protection_ctrl;
  logic       ref_clk;
  logic       nrst;
  logic [5:0] iv;
  logic [4:0] o;
  logic [1:0] p;
  int         fail_count;
  int         n_tests;
  afp_ctrl afp_ctrl_i (.ref_clk(ref_clk), .nrst(nrst),
    .uv_gate_drive_supply(iv[5]), .uv_logic_supply(iv[4]),
    .overtemp_warn_flag(iv[3]), .overtemp_error(iv[2]),
    .overcurrent(iv[1]), .reset_pin_n(iv[0]), .stage_enable(o[4]),
    .current_limit(o[3]), .shutdown_fault_n_out(), .shutdown_fault_n_oe(o[2]),
    .overtemp_warn_n_out(), .overtemp_warn_n_oe(o[1]),
    .overload_protection(o[0]));
  afp_host_model afp_host_model_i (.shdn_oe(o[2]), .warn_oe(o[1]),
    .shdn_pin(p[1]), .warn_pin(p[0]));
  task automatic end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // inputs {uvg, uvl, warn, err, oc, rst_n}, outputs {en, lim, sd, otw, olp}
  task automatic step(logic [5:0] v, logic [4:0] e);
    @(posedge ref_clk);
    #1 iv = v;
    repeat (10) @(posedge ref_clk);
    #1 n_tests++;
    if ({o[4:3], p, o[0]} !== e) begin
      fail_count++;
      $display("CHECK FAILED outputs for in %h exp %h got %h", v, e,
               {o[4:3], p, o[0]});
    end
  endtask : step
  task automatic t_supply;
    step(6'h31, 5'h02);
    step(6'h01, 5'h16);
    step(6'h21, 5'h02);
    step(6'h11, 5'h02);
  endtask : t_supply
  task automatic t_temp;
    step(6'h09, 5'h14);
    step(6'h0D, 5'h00);
    step(6'h28, 5'h06);
  endtask : t_temp
  task automatic t_current;
    step(6'h03, 5'h1E);
    step(6'h01, 5'h16);
    step(6'h30, 5'h06);
  endtask : t_current
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #20us;
    fail_count++;
    end_of_test();
  end
  initial begin
    nrst = 1'h0;
    iv = 6'h30;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(posedge ref_clk);
    #1 nrst = 1'h1;
    t_supply();
    t_temp();
    t_current();
    end_of_test();
  end
endmodule : test_amp_fault_protection_ctrl

// ===== verilog/afp_ctrl.sv
// fault protection and error reporting of the amplifier power stage
`timescale 1ns/1ps
module afp_ctrl (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic uv_gate_drive_supply,
  input  wire logic uv_logic_supply,
  input  wire logic overtemp_warn_flag,
  input  wire logic overtemp_error,
  input  wire logic overcurrent,
  input  wire logic reset_pin_n,
  output logic      stage_enable,
  output logic      current_limit,
  output logic      shutdown_fault_n_out,
  output logic      shutdown_fault_n_oe,
  output logic      overtemp_warn_n_out,
  output logic      overtemp_warn_n_oe,
  output logic      overload_protection
);
  typedef struct packed {
    logic                        rs1;
    logic                        rs2;
    afp_pkg::afp_state_e         state;
    logic [afp_pkg::CNT_W-1:0]   ovld_cnt;
    logic                        rst_prev;
    logic                        en;
    logic                        shdn_oe;
    logic                        warn_oe;
    logic                        ilim;
  } afp_ctrl_s;

  afp_ctrl_s st_q;
  afp_ctrl_s st_d;
  logic      rst_n;
  logic      any_fault;
  logic      uv;

  afp_fault_if flt ();

  afp_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pins    ({reset_pin_n, overcurrent, overtemp_error, overtemp_warn_flag,
               uv_logic_supply, uv_gate_drive_supply}),
    .flt     (flt)
  );

  assign rst_n = st_q.rs2;

  always_comb begin
    st_d     = st_q;
    st_d.rs1 = 1'b1;
    st_d.rs2 = st_q.rs1;
    uv       = flt.uv_gate | flt.uv_logic;
    any_fault = 1'b0;
    st_d.rst_prev = flt.rst_in_n;
    unique case (st_q.state)
      afp_pkg::AFP_ST_OFF: begin
        st_d.ovld_cnt = afp_pkg::CNT_ZERO;
        if (!uv && flt.rst_in_n) begin
          st_d.state = afp_pkg::AFP_ST_RUN;
        end
      end
      afp_pkg::AFP_ST_RUN: begin
        if (flt.overcurrent) begin
          if (st_q.ovld_cnt == afp_pkg::CNT_W'(afp_pkg::OVLD_CYCLES - 1)) begin
            st_d.state    = afp_pkg::AFP_ST_LTCH;
            st_d.ovld_cnt = afp_pkg::CNT_ZERO;
          end else begin
            st_d.ovld_cnt = st_q.ovld_cnt + afp_pkg::CNT_ONE;
          end
        end else begin
          st_d.ovld_cnt = afp_pkg::CNT_ZERO;
        end
        if (uv || flt.ot_err || !flt.rst_in_n) begin
          st_d.state = afp_pkg::AFP_ST_OFF;
        end
      end
      afp_pkg::AFP_ST_LTCH: begin
        st_d.ovld_cnt = afp_pkg::CNT_ZERO;
        if (flt.rst_in_n && !st_q.rst_prev) begin
          st_d.state = afp_pkg::AFP_ST_OFF;
        end
      end
    endcase
    // faults are decoded here and reach the stage through the registered enable one cycle later
    any_fault = uv | flt.ot_err | (st_d.state == afp_pkg::AFP_ST_LTCH);
    st_d.en   = (st_d.state == afp_pkg::AFP_ST_RUN) && !any_fault
                && flt.rst_in_n;
    st_d.ilim = flt.overcurrent && (st_d.state == afp_pkg::AFP_ST_RUN);
    st_d.shdn_oe = flt.rst_in_n && any_fault;
    st_d.warn_oe = flt.rst_in_n && (flt.ot_warn || flt.ot_err);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{rs1: 1'b0, rs2: 1'b0, state: afp_pkg::AFP_ST_OFF,
                ovld_cnt: afp_pkg::CNT_ZERO, rst_prev: 1'b0, en: 1'b0,
                shdn_oe: 1'b0, warn_oe: 1'b0, ilim: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign stage_enable         = st_q.en;
  assign current_limit        = st_q.ilim;
  assign shutdown_fault_n_out = 1'b0;
  assign shutdown_fault_n_oe  = st_q.shdn_oe;
  assign overtemp_warn_n_out  = 1'b0;
  assign overtemp_warn_n_oe   = st_q.warn_oe;
  assign overload_protection  = (st_q.state == afp_pkg::AFP_ST_LTCH);
endmodule : afp_ctrl

// ===== verilog/afp_fault_if.sv
// fault indications passed from the synchroniser to the controller
`timescale 1ns/1ps
interface afp_fault_if;
  logic uv_gate;
  logic uv_logic;
  logic ot_warn;
  logic ot_err;
  logic overcurrent;
  logic rst_in_n;
  modport src (output uv_gate, uv_logic, ot_warn, ot_err, overcurrent,
               rst_in_n);
  modport dst (input uv_gate, uv_logic, ot_warn, ot_err, overcurrent,
               rst_in_n);
endinterface : afp_fault_if

// ===== verilog/afp_pkg.sv
// constants and types shared by the fault protection controller
package afp_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  // overload persistence time in microseconds
  localparam int unsigned OVLD_US        = 1250;
  localparam longint unsigned OVLD_CYC_L =
    (longint'(OVLD_US) * longint'(CLK_HZ) + 64'd999_999) / 64'd1_000_000;
  localparam int unsigned OVLD_CYCLES    = int'(OVLD_CYC_L);
  localparam int unsigned CNT_W          = 20;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 20'h0_0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 20'h0_0001;

  typedef enum logic [2:0] {
    AFP_ST_OFF  = 3'b001,
    AFP_ST_RUN  = 3'b010,
    AFP_ST_LTCH = 3'b100
  } afp_state_e;
endpackage : afp_pkg

// ===== verilog/afp_sync.sv
// two-flop synchroniser for detector and reset pin inputs
`timescale 1ns/1ps
module afp_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic [5:0] pins,
  afp_fault_if.src  flt
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } afp_sync_s;

  afp_sync_s st_q;
  afp_sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{s1: 6'h00, s2: 6'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign flt.uv_gate     = st_q.s2[0];
  assign flt.uv_logic    = st_q.s2[1];
  assign flt.ot_warn     = st_q.s2[2];
  assign flt.ot_err      = st_q.s2[3];
  assign flt.overcurrent = st_q.s2[4];
  assign flt.rst_in_n    = st_q.s2[5];
endmodule : afp_sync
